// ==== design/qecc_top.v ====
// encoder counter control: control register, counters, index handling
// assumes APB master, encoder pins already synchronous to core_clk
`include "qecc_regs.vh"
module qecc_top (
  // clock and reset
  input wire core_clk,
  input wire rst,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`QECC_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // encoder pins
  input wire phase_a,
  input wire phase_b,
  input wire index_in,
  input wire home_in,
  // device power state
  input wire idle_mode,
  // status out
  output reg running_q,
  output reg dir_up_q
);

  // control register and threshold registers
  reg [15:0] ctrl_q;
  reg [31:0] init_q;
  reg [31:0] low_q;
  // home tracking for index-after-home modes
  reg home_seen_q;
  reg idx_after_home_q;
  // one-shot arm for next-index mode
  reg next_armed_q;
  reg [2:0] pim_last_q;

  // decoded control fields
  wire en_bit = ctrl_q[`QECC_B_EN];
  wire idle_stop = ctrl_q[`QECC_B_IDLE];
  wire [2:0] pim = ctrl_q[`QECC_PIM_HI:`QECC_PIM_LO];
  wire gaten = ctrl_q[`QECC_B_GATEN];
  wire [1:0] ccm = ctrl_q[`QECC_CCM_HI:`QECC_CCM_LO];

  // counters run only when enabled and not stopped by idle
  wire run = en_bit & ~(idle_stop & idle_mode);

  // apb phases
  wire acc = psel & penable;
  wire wr_go = acc & pready & pwrite;
  wire rd_go = acc & ~pready & ~pwrite;

  // address decode
  wire sel_ctrl = (paddr == `QECC_OFS_CTRL);
  wire sel_pos = (paddr == `QECC_OFS_POS);
  wire sel_idx = (paddr == `QECC_OFS_IDX);
  wire sel_tmr = (paddr == `QECC_OFS_TMR);
  wire sel_vel = (paddr == `QECC_OFS_VEL);
  wire sel_init = (paddr == `QECC_OFS_INIT);
  wire sel_low = (paddr == `QECC_OFS_LOW);
  wire sel_stat = (paddr == `QECC_OFS_STAT);
  wire mapped = sel_ctrl | sel_pos | sel_idx | sel_tmr | sel_vel | sel_init | sel_low | sel_stat;

  // edges of the encoder inputs
  wire a_prev;
  wire b_prev;
  wire a_rise;
  wire a_fall;
  wire b_rise;
  wire b_fall;
  wire i_rise;
  wire h_rise;

  qecc_edge u_edge_a (
    .core_clk(core_clk),
    .rst(rst),
    .in_lvl(phase_a),
    .prev_q(a_prev),
    .rise(a_rise),
    .fall(a_fall)
  );

  qecc_edge u_edge_b (
    .core_clk(core_clk),
    .rst(rst),
    .in_lvl(phase_b),
    .prev_q(b_prev),
    .rise(b_rise),
    .fall(b_fall)
  );

  qecc_edge u_edge_i (
    .core_clk(core_clk),
    .rst(rst),
    .in_lvl(index_in),
    .prev_q(),
    .rise(i_rise),
    .fall()
  );

  qecc_edge u_edge_h (
    .core_clk(core_clk),
    .rst(rst),
    .in_lvl(home_in),
    .prev_q(),
    .rise(h_rise),
    .fall()
  );

  // position step and direction per count mode
  reg pos_step;
  reg pos_up;
  wire a_edge = a_rise | a_fall;
  wire b_edge = b_rise | b_fall;

  // count mode decode
  always @* begin
    pos_step = 1'b0;
    pos_up = dir_up_q;
    case (ccm)
      `QECC_CCM_QUAD: begin
        // every edge of either phase counts once
        pos_step = a_edge | b_edge;
        // a leading b counts up, b leading a counts down
        if (a_edge) begin
          pos_up = phase_a ^ b_prev;
        end else begin
          pos_up = ~(phase_b ^ a_prev);
        end
      end
      `QECC_CCM_UPDN: begin
        // phase a pulses count, phase b gives direction
        pos_step = a_rise;
        pos_up = phase_b;
      end
      `QECC_CCM_GCNT: begin
        // phase a pulses count only while phase b gate is high
        pos_step = a_rise & phase_b;
        pos_up = 1'b1;
      end
      `QECC_CCM_TMR: begin
        // internal timer; gated timer when gate enable is set
        pos_step = gaten ? phase_b : 1'b1;
        pos_up = 1'b1;
      end
      default: begin
        pos_step = 1'b0;
        pos_up = dir_up_q;
      end
    endcase
  end

  // position counter value and index loading
  wire [31:0] pos_cnt;
  wire step_ok = run & pos_step;
  reg pos_ld;
  reg [31:0] pos_ld_val;

  // index event handling per position init mode
  always @* begin
    pos_ld = 1'b0;
    pos_ld_val = init_q;
    if (run) begin
      case (pim)
        `QECC_PIM_NONE: begin
          // index leaves position alone
          pos_ld = 1'b0;
        end
        `QECC_PIM_EVERY: begin
          // every index clears position
          pos_ld = i_rise;
          pos_ld_val = 32'h00000000;
        end
        `QECC_PIM_NEXT: begin
          // next index loads the init value once
          pos_ld = i_rise & next_armed_q;
        end
        `QECC_PIM_HOME1: begin
          // first index after home loads init value
          pos_ld = i_rise & home_seen_q;
        end
        `QECC_PIM_HOME2: begin
          // second index after home loads init value
          pos_ld = i_rise & home_seen_q & idx_after_home_q;
        end
        `QECC_PIM_CMPRST: begin
          // position clears on the step taken while it equals upper compare
          pos_ld = step_ok & (pos_cnt == init_q);
          pos_ld_val = 32'h00000000;
        end
        `QECC_PIM_MOD: begin
          // wrap between lower and upper limits
          if (step_ok & pos_up & (pos_cnt == init_q)) begin
            pos_ld = 1'b1;
            pos_ld_val = low_q;
          end else if (step_ok & ~pos_up & (pos_cnt == low_q)) begin
            pos_ld = 1'b1;
            pos_ld_val = init_q;
          end
        end
        default: begin
          // reserved code does nothing
          pos_ld = 1'b0;
        end
      endcase
    end
  end

  // 32-bit position counter
  qecc_cnt #(.W(32)) u_pos (
    .core_clk(core_clk),
    .rst(rst),
    .wr_en(wr_go & sel_pos),
    .wr_val(pwdata),
    .ld_en(pos_ld),
    .ld_val(pos_ld_val),
    .step_en(step_ok),
    .step_up(pos_up),
    .cnt_q(pos_cnt)
  );

  // load inputs of counters that software alone presets
  wire no_ld = 1'b0;
  wire [31:0] no_ld_val = 32'h00000000;
  // 32-bit index pulse counter
  wire [31:0] idx_cnt;
  qecc_cnt #(.W(32)) u_idx (
    .core_clk(core_clk),
    .rst(rst),
    .wr_en(wr_go & sel_idx),
    .wr_val(pwdata),
    .ld_en(no_ld),
    .ld_val(no_ld_val),
    .step_en(run & i_rise),
    .step_up(dir_up_q),
    .cnt_q(idx_cnt)
  );

  // 32-bit interval timer, counts core clocks while running
  wire [31:0] tmr_cnt;
  qecc_cnt #(.W(32)) u_tmr (
    .core_clk(core_clk),
    .rst(rst),
    .wr_en(wr_go & sel_tmr),
    .wr_val(pwdata),
    .ld_en(no_ld),
    .ld_val(no_ld_val),
    .step_en(run),
    .step_up(1'b1),
    .cnt_q(tmr_cnt)
  );

  // 16-bit velocity counter follows position steps
  wire [15:0] vel_cnt;
  qecc_cnt #(.W(16)) u_vel (
    .core_clk(core_clk),
    .rst(rst),
    .wr_en(wr_go & sel_vel),
    .wr_val(pwdata[15:0]),
    .ld_en(no_ld),
    .ld_val(no_ld_val[15:0]),
    .step_en(step_ok),
    .step_up(pos_up),
    .cnt_q(vel_cnt)
  );

  // software registers, writable at any time
  always @(posedge core_clk) begin
    if (rst) begin
      ctrl_q <= `QECC_CTRL_RST;
      init_q <= 32'h00000000;
      low_q <= 32'h00000000;
    end else if (wr_go) begin
      if (sel_ctrl) begin
        // bit 14 and upper half never stored
        ctrl_q <= pwdata[15:0] & `QECC_CTRL_MASK;
      end
      if (sel_init) begin
        init_q <= pwdata;
      end
      if (sel_low) begin
        low_q <= pwdata;
      end
    end
  end

  // home and index tracking for home modes and next-index arm
  always @(posedge core_clk) begin
    if (rst) begin
      home_seen_q <= 1'b0;
      idx_after_home_q <= 1'b0;
      next_armed_q <= 1'b0;
      pim_last_q <= `QECC_PIM_NONE;
    end else begin
      pim_last_q <= pim;
      // a change of mode restarts the sequences
      if (pim != pim_last_q) begin
        home_seen_q <= 1'b0;
        idx_after_home_q <= 1'b0;
        next_armed_q <= (pim == `QECC_PIM_NEXT);
      end else if (run) begin
        if (pos_ld & i_rise) begin
          // a load ends the sequence
          home_seen_q <= h_rise;
          idx_after_home_q <= 1'b0;
          next_armed_q <= 1'b0;
        end else if (h_rise) begin
          // home starts a fresh count of index events
          home_seen_q <= 1'b1;
          idx_after_home_q <= 1'b0;
        end else if (i_rise & home_seen_q) begin
          idx_after_home_q <= 1'b1;
        end
      end
    end
  end

  // status flops driven to the pins
  always @(posedge core_clk) begin
    if (rst) begin
      running_q <= 1'b0;
      dir_up_q <= 1'b1;
    end else begin
      running_q <= run;
      if (step_ok) begin
        dir_up_q <= pos_up;
      end
    end
  end

  // read mux for the current address
  reg [31:0] rd_val;
  always @* begin
    rd_val = 32'h00000000;
    case (1'b1)
      sel_ctrl: rd_val = {16'h0000, ctrl_q};
      sel_pos: rd_val = pos_cnt;
      sel_idx: rd_val = idx_cnt;
      sel_tmr: rd_val = tmr_cnt;
      sel_vel: rd_val = {16'h0000, vel_cnt};
      sel_init: rd_val = init_q;
      sel_low: rd_val = low_q;
      sel_stat: rd_val = {26'h0000000, dir_up_q, running_q, idx_after_home_q,
                          home_seen_q, phase_b, phase_a};
      default: rd_val = 32'h00000000;
    endcase
  end

  // apb answer: one wait state, then ready with data or error
  always @(posedge core_clk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= acc & ~pready;
      pslverr <= acc & ~pready & ~mapped;
      if (rd_go) begin
        // reads work whether or not counters run
        prdata <= mapped ? rd_val : 32'h00000000;
      end
    end
  end

endmodule

// ==== design/qecc_regs.vh ====
// register map, field positions and codes of the encoder counter control
// assumes APB with 32-bit data; each register takes one aligned word
//
// Behaviour
// - enable bit 15 runs or stops counters
// - registers stay readable and writable while stopped
// - control bit 14 reads zero, ignores writes
// - idle stop bit 13 halts in idle
// - init mode in bits 12..10, 111 reserved
// - one mode wraps position between limits
// - one mode loads position on next index
// - one mode loads on index after home
// - one mode ignores index for position
// - provide position, index, interval, velocity counters
// - init, capture and upper compare register; init_q here only loads and compares, no capture
// - separate lower compare register
// - x4 quadrature and external up/down counting
// - gated count, gated timer, internal timer
`ifndef QECC_REGS_VH
`define QECC_REGS_VH

// word byte offsets
`define QECC_ADDR_W 8
`define QECC_OFS_CTRL 8'h00
`define QECC_OFS_POS 8'h04
`define QECC_OFS_IDX 8'h08
`define QECC_OFS_TMR 8'h0C
`define QECC_OFS_VEL 8'h10
`define QECC_OFS_INIT 8'h14
`define QECC_OFS_LOW 8'h18
`define QECC_OFS_STAT 8'h1C

// control field positions
`define QECC_B_EN 15
`define QECC_B_IDLE 13
`define QECC_PIM_HI 12
`define QECC_PIM_LO 10
`define QECC_B_GATEN 2
`define QECC_CCM_HI 1
`define QECC_CCM_LO 0
// writable control bits; only bit 14 stays zero
`define QECC_CTRL_MASK 16'hBFFF
`define QECC_CTRL_RST 16'h0000

// position init mode codes
`define QECC_PIM_NONE 3'h0
`define QECC_PIM_EVERY 3'h1
`define QECC_PIM_NEXT 3'h2
`define QECC_PIM_HOME1 3'h3
`define QECC_PIM_HOME2 3'h4
`define QECC_PIM_CMPRST 3'h5
`define QECC_PIM_MOD 3'h6

// count mode codes
`define QECC_CCM_QUAD 2'h0
`define QECC_CCM_UPDN 2'h1
`define QECC_CCM_GCNT 2'h2
`define QECC_CCM_TMR 2'h3

`endif

// ==== design/qecc_edge.v ====
// edge detector for one encoder input
// assumes the input is already synchronous to core_clk
module qecc_edge (
  // clock and reset
  input wire core_clk,
  input wire rst,
  // input level and edges
  input wire in_lvl,
  output reg prev_q,
  output wire rise,
  output wire fall
);
  // previous level for edge compare
  always @(posedge core_clk) begin
    if (rst) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= in_lvl;
    end
  end

  assign rise = in_lvl & ~prev_q;
  assign fall = ~in_lvl & prev_q;
endmodule

// ==== design/qecc_cnt.v ====
// up/down counter with software write and hardware load
// assumes write has priority over load, load over step
module qecc_cnt #(
  parameter W = 32
) (
  // clock and reset
  input wire core_clk,
  input wire rst,
  // software write
  input wire wr_en,
  input wire [W-1:0] wr_val,
  // hardware load
  input wire ld_en,
  input wire [W-1:0] ld_val,
  // counting step
  input wire step_en,
  input wire step_up,
  // count value
  output reg [W-1:0] cnt_q
);
  // one step of the counter per enabled cycle
  always @(posedge core_clk) begin
    if (rst) begin
      cnt_q <= {W{1'b0}};
    end else if (wr_en) begin
      cnt_q <= wr_val;
    end else if (ld_en) begin
      cnt_q <= ld_val;
    end else if (step_en) begin
      if (step_up) begin
        cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
      end else begin
        cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule

// ==== dv/qecc_checker.sv ====
// port assertions for the encoder counter control
// assumes bind onto qecc_top; control shadowed from apb writes
`include "qecc_regs.vh"
module qecc_checker (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`QECC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // encoder and status
  input wire logic phase_a,
  input wire logic phase_b,
  input wire logic idle_mode,
  input wire logic running_q,
  input wire logic dir_up_q
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] ctl_q; // shadow of the control register
  logic run_c; // counters may step this cycle
  logic quad_c; // running in x4 mode
  // follow completed control writes
  always @(posedge core_clk) begin
    if (rst) ctl_q <= 16'h0000;
    else if (psel && penable && pready && pwrite && paddr == `QECC_OFS_CTRL) ctl_q <= pwdata[15:0] & `QECC_CTRL_MASK;
  end
  assign run_c = ctl_q[15] && !(ctl_q[13] && idle_mode);
  assign quad_c = run_c && ctl_q[1:0] == 2'h0;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_ready_next: assert property (psel && penable && !pready |=> pready) else $error("late ready");
  a_ready_pulse: assert property (pready |=> !pready) else $error("long ready");
  a_err_ready: assert property (pslverr |-> pready) else $error("lone error");
  a_ctrl_read: assert property (pready && !pwrite && paddr == 8'h00 |-> prdata == {16'h0000, ctl_q})
    else $error("ctrl read");
  a_run_follow: assert property (!$past(rst) |-> running_q == $past(run_c))
    else $error("run state");
  a_dir_hold: assert property (!run_c |=> $stable(dir_up_q)) else $error("dir moved");
  a_dir_a_rise: assert property (quad_c && $rose(phase_a) && !$past(rst) |=> dir_up_q != $past(phase_b))
    else $error("dir a");
  a_dir_b_rise: assert property (quad_c && $rose(phase_b) && !$past(rst) |=> dir_up_q == $past(phase_a))
    else $error("dir b");
  a_rdata_src: assert property ($changed(prdata) |-> pready && !pwrite) else $error("rdata moved");
endmodule
bind qecc_top qecc_checker qecc_checker_inst (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .phase_a(phase_a), .phase_b(phase_b), .idle_mode(idle_mode), .running_q(running_q), .dir_up_q(dir_up_q));

// ==== dv/qecc_enc_model.sv ====
// incremental encoder model driving phases, index and home
// assumes tasks are called right after a core_clk edge
module qecc_enc_model (
  // clock
  input wire logic core_clk,
  // encoder pins
  output logic phase_a,
  output logic phase_b,
  output logic index_in,
  output logic home_in
);
  timeunit 1ns;
  timeprecision 100ps;
  int st = 0; // quadrature state 0..3
  initial begin
    phase_a = 1'b0;
    phase_b = 1'b0;
    index_in = 1'b0;
    home_in = 1'b0;
  end
  // one edge; a leading b is the up sense
  task automatic step(input bit up);
    @(posedge core_clk);
    st = up ? (st + 1) % 4 : (st + 3) % 4;
    phase_a <= (st == 1 || st == 2);
    phase_b <= (st >= 2);
    repeat (2) @(posedge core_clk);
  endtask
  // one-cycle index or home pulse
  task automatic pulse(input bit home);
    @(posedge core_clk);
    if (home) home_in <= 1'b1;
    else index_in <= 1'b1;
    @(posedge core_clk);
    home_in <= 1'b0;
    index_in <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask
  // direct levels for count and direction mode
  task automatic pins(input logic [1:0] ba);
    @(posedge core_clk);
    {phase_b, phase_a} <= ba;
    repeat (2) @(posedge core_clk);
  endtask
endmodule

// ==== dv/testbench.sv ====
// self-checking bench for the encoder counter control
// assumes the checker binds itself onto qecc_top
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk, rst, psel, penable, pwrite, idle_mode, run, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, rd, exp_pos, ini;
  wire [31:0] prdata;
  wire pready, pslverr, running_q, dir_up_q, phase_a, phase_b, index_in, home_in;
  int fails = 0;
  int n_tests = 0;
  logic [7:0] ofs [4]; // registers preset while stopped
  bit last_up = 1'b1; // direction of the last counted edge
  qecc_top qecc_top_inst (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .phase_a(phase_a),
    .phase_b(phase_b), .index_in(index_in), .home_in(home_in), .idle_mode(idle_mode), .running_q(running_q),
    .dir_up_q(dir_up_q));
  qecc_enc_model qecc_enc_model_inst (.core_clk(core_clk), .phase_a(phase_a), .phase_b(phase_b),
    .index_in(index_in), .home_in(home_in));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one apb transfer; read data and error land in rd and er
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) begin
      fails++;
      print_verdict();
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk("register", e, rd);
  endtask
  // one quadrature edge, mirrored in the position model
  task automatic move(input bit up);
    qecc_enc_model_inst.step(up);
    if (run) begin
      exp_pos = up ? exp_pos + 1 : exp_pos - 1;
      last_up = up;
    end
  endtask
  initial begin
    repeat (100000) @(posedge core_clk);
    fails++;
    print_verdict();
  end
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    idle_mode = 1'b0;
    run = 1'b0;
    void'($urandom(91515));
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++) rdc(8'(i * 4), 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk("slverr", 32'h1, {31'h0, er});
    apb(1'b1, 8'h00, 32'hFFFFFFFF);
    rdc(8'h00, 32'h0000BFFF);
    apb(1'b1, 8'h00, 32'h0);
    $display("reset and control done");
    ofs = '{8'h04, 8'h08, 8'h14, 8'h18};
    foreach (ofs[i]) begin
      ini = $urandom;
      apb(1'b1, ofs[i], ini);
      rdc(ofs[i], ini);
    end
    exp_pos = ini;
    apb(1'b1, 8'h04, exp_pos);
    move(1'b1);
    rdc(8'h04, exp_pos);
    $display("stopped access done");
    apb(1'b1, 8'h00, 32'h8000);
    run = 1'b1;
    repeat (24) move(1'($urandom));
    rdc(8'h04, exp_pos);
    chk("dir_up", {31'h0, last_up}, {31'h0, dir_up_q});
    chk("running", 32'h1, {31'h0, running_q});
    idle_mode <= 1'b1;
    apb(1'b1, 8'h00, 32'hA000);
    run = 1'b0;
    move(1'b1);
    rdc(8'h04, exp_pos);
    chk("running", 32'h0, {31'h0, running_q});
    apb(1'b1, 8'h00, 32'h8000);
    run = 1'b1;
    move(1'b0);
    rdc(8'h04, exp_pos);
    idle_mode <= 1'b0;
    qecc_enc_model_inst.pulse(1'b0);
    rdc(8'h04, exp_pos);
    $display("quadrature and idle done");
    ini = $urandom;
    apb(1'b1, 8'h14, ini);
    apb(1'b1, 8'h00, 32'h8800);
    qecc_enc_model_inst.pulse(1'b0);
    exp_pos = ini;
    rdc(8'h04, exp_pos);
    move(1'b1);
    qecc_enc_model_inst.pulse(1'b0);
    rdc(8'h04, exp_pos);
    apb(1'b1, 8'h00, 32'h8C00);
    qecc_enc_model_inst.pulse(1'b0);
    rdc(8'h04, exp_pos);
    qecc_enc_model_inst.pulse(1'b1);
    qecc_enc_model_inst.pulse(1'b0);
    exp_pos = ini;
    rdc(8'h04, exp_pos);
    move(1'b1);
    apb(1'b1, 8'h00, 32'h9000);
    qecc_enc_model_inst.pulse(1'b1);
    qecc_enc_model_inst.pulse(1'b0);
    rdc(8'h04, exp_pos);
    qecc_enc_model_inst.pulse(1'b0);
    exp_pos = ini;
    rdc(8'h04, exp_pos);
    apb(1'b1, 8'h00, 32'h8400);
    qecc_enc_model_inst.pulse(1'b0);
    exp_pos = 32'h0;
    rdc(8'h04, exp_pos);
    apb(1'b1, 8'h00, 32'h9C00);
    qecc_enc_model_inst.pulse(1'b0);
    rdc(8'h04, exp_pos);
    $display("index modes done");
    apb(1'b1, 8'h18, 32'h5);
    apb(1'b1, 8'h14, 32'h8);
    apb(1'b1, 8'h04, 32'h8);
    apb(1'b1, 8'h00, 32'h9800);
    move(1'b1);
    rdc(8'h04, 32'h5);
    move(1'b0);
    rdc(8'h04, 32'h8);
    apb(1'b1, 8'h00, 32'h9400);
    move(1'b1);
    exp_pos = 32'h0;
    rdc(8'h04, exp_pos);
    apb(1'b1, 8'h00, 32'h0);
    qecc_enc_model_inst.pins(2'b00);
    apb(1'b1, 8'h00, 32'h8001);
    qecc_enc_model_inst.pins(2'b10);
    qecc_enc_model_inst.pins(2'b11);
    rdc(8'h04, exp_pos + 1);
    qecc_enc_model_inst.pins(2'b00);
    qecc_enc_model_inst.pins(2'b01);
    rdc(8'h04, exp_pos);
    $display("modulo and up/down done");
    apb(1'b1, 8'h00, 32'h8002);
    qecc_enc_model_inst.pins(2'b00);
    qecc_enc_model_inst.pins(2'b01);
    rdc(8'h04, exp_pos);
    qecc_enc_model_inst.pins(2'b00);
    qecc_enc_model_inst.pins(2'b11);
    rdc(8'h04, exp_pos + 1);
    qecc_enc_model_inst.pins(2'b00);
    apb(1'b1, 8'h00, 32'h8007);
    qecc_enc_model_inst.pins(2'b01);
    rdc(8'h04, exp_pos + 1);
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b0, 8'h0C, 32'h0);
    ini = rd;
    rdc(8'h0C, ini);
    $display("gated modes done");
    print_verdict();
  end
endmodule
